/* rtl/dsl_freq_cond.sv */
// Combinational conditioning of the requested frequency.
// Assumes all settings are already within their legal ranges.
`timescale 1ns/1ns
module dsl_freq_cond
	import dsl_pkg::*;
(
	input wire logic [15:0] req,
	input wire logic [15:0] start_f,
	input wire logic [15:0] max_f,
	input wire logic [15:0] lim_lo,
	input wire logic [15:0] lim_hi,
	input wire logic lim_en,
	input wire logic jump_en,
	input wire logic [15:0] floor_f [3],
	input wire logic [15:0] ceil_f [3],
	output logic [15:0] cond
);
	// Clamp, then skip hold, then start zeroing; the order matters because a
	// band floor below the start frequency must still read as zero.
	always_comb begin
		logic [15:0] c;
		c = 16'h0000;
		c = (req > max_f) ? max_f : req; // see (RL5)
		if (lim_en) begin
			c = sat(c, lim_lo, (lim_hi > max_f) ? max_f : lim_hi); // see (RL6)
		end
		if (jump_en) begin
			for (int k = 0; k < 3; k++) begin
				// A request inside a band waits at its floor until it reaches the ceiling.
				if (c > floor_f[k] && c < ceil_f[k]) begin
					c = floor_f[k]; // see (RL11)
				end
			end
		end
		cond = (c < start_f) ? 16'h0000 : c; // see (RL4) see (RL15)
	end
endmodule : dsl_freq_cond

/* rtl/dsl_limiter.sv */
// Speed reference limiter and stop method sequencer, AHB-Lite slave.
// Assumes one AHB-Lite master, single word transfers, 100 MHz REF_CLK.
`timescale 1ns/1ns
module dsl_limiter
	import dsl_pkg::*;
#(
	parameter int FW = 16 // Frequency word width.
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [15:0] DC_LINK_V,
	input wire logic STALL_REQ,
	output logic OUT_EN,
	output logic [15:0] OUT_FREQ,
	output logic DECEL,
	output logic PB_ACT,
	output logic STALL_ACT
);

	// ----------------------------------------
	// Elaboration check.
	// ----------------------------------------
	if (FW != 16) begin : g_fw_chk
		$error("dsl_limiter supports only a 16-bit frequency word");
	end

	// ----------------------------------------
	// Reset and bus state.
	// ----------------------------------------
	logic rst_n; // Synchronised reset.
	logic wr_pend; // A write data phase is due.
	logic [7:0] wr_addr; // Offset captured in the address phase.
	logic [15:0] wdat; // Low half of the write data.
	logic addr_ok; // Valid address phase this cycle.

	// ----------------------------------------
	// Settings.
	// ----------------------------------------
	logic run_cmd; // Run command from software.
	logic [2:0] stop_m; // Stop method.
	logic lim_en; // Limit enable.
	logic jump_en; // Skip band enable.
	logic stall_sel; // Stall prevention select.
	logic [15:0] fref; // Requested frequency.
	logic [15:0] start_f; // Start frequency.
	logic [15:0] max_f; // Maximum frequency.
	logic [15:0] lim_lo; // Lower limit.
	logic [15:0] lim_hi; // Upper limit.
	logic [15:0] base_f; // Base speed, exempt from upper limit.
	logic [15:0] dc_thr; // DC link threshold for power braking.
	logic [15:0] step; // Ramp step per tick.
	logic [15:0] floor_f [3]; // Band floors.
	logic [15:0] ceil_f [3]; // Band ceilings.

	// ----------------------------------------
	// Sequencer state.
	// ----------------------------------------
	dsl_state_e state; // Stop sequencer state.
	logic [15:0] target; // Conditioned reference.
	logic [$clog2(TICK_CYC)-1:0] tick_cnt; // Ramp tick divider.
	logic tick; // One cycle per ramp step.
	logic pb_hold; // Power braking condition.
	logic stall_hold; // Stall prevention condition.

	dsl_rst_sync u_rst (
		.clk(REF_CLK),
		.arst_n(RST_N),
		.rst_n(rst_n)
	);

	dsl_freq_cond u_cond (
		.req(fref),
		.start_f(start_f),
		.max_f(max_f),
		.lim_lo(lim_lo),
		.lim_hi(lim_hi),
		.lim_en(lim_en),
		.jump_en(jump_en),
		.floor_f(floor_f),
		.ceil_f(ceil_f),
		.cond(target)
	);

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------

	// Cap a speed setting at the upper limit while limits are on.
	function automatic logic [15:0] cap(input logic [15:0] v);
		cap = (lim_en && v > lim_hi) ? lim_hi : v; // see (RL8)
	endfunction : cap

	// One ramp step toward a goal; a step landing in a band is carried through it.
	function automatic logic [15:0] ramp(input logic [15:0] cur, input logic [15:0] goal);
		logic [16:0] up;
		logic [15:0] n;
		up = {1'b0, cur} + {1'b0, step};
		n = cur;
		if (goal > cur) begin
			n = (up > {1'b0, goal}) ? goal : up[15:0];
		end else if (goal < cur) begin
			n = (cur - goal > step) ? cur - step : goal;
		end
		if (jump_en) begin
			for (int k = 0; k < 3; k++) begin
				if (n > floor_f[k] && n < ceil_f[k]) begin
					n = (goal > cur) ? ceil_f[k] : floor_f[k]; // see (RL12)
				end
			end
		end
		ramp = n;
	endfunction : ramp

	// ----------------------------------------
	// AHB-Lite slave.
	// ----------------------------------------
	assign addr_ok = HSEL && HTRANS[1] && HREADY;
	assign wdat = HWDATA[15:0];

	// Zero wait state slave: ready and OKAY are fixed after reset.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Capture the write address so the data phase knows its target.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ok && HWRITE;
			wr_addr <= HADDR[7:0];
		end
	end

	// Read data is registered in the address phase so it stands for the data
	// phase; unmapped offsets and hidden limits read as zero.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			HRDATA <= 32'h0000_0000;
		end else if (addr_ok && !HWRITE) begin
			HRDATA <= 32'h0000_0000;
			if (HADDR[7:0] == OFS_CTRL) begin
				HRDATA[6:0] <= {stall_sel, jump_en, lim_en, stop_m, run_cmd};
			end else if (HADDR[7:0] == OFS_FREF) begin
				HRDATA[15:0] <= fref;
			end else if (HADDR[7:0] == OFS_START) begin
				HRDATA[15:0] <= start_f;
			end else if (HADDR[7:0] == OFS_MAX) begin
				HRDATA[15:0] <= max_f;
			end else if (HADDR[7:0] == OFS_LIM_LO) begin
				HRDATA[15:0] <= lim_en ? lim_lo : 16'h0000; // see (RL7)
			end else if (HADDR[7:0] == OFS_LIM_HI) begin
				HRDATA[15:0] <= lim_en ? lim_hi : 16'h0000; // see (RL7)
			end else if (HADDR[7:0] == OFS_BASE) begin
				HRDATA[15:0] <= base_f;
			end else if (HADDR[7:0] == OFS_DC_THR) begin
				HRDATA[15:0] <= dc_thr;
			end else if (HADDR[7:0] == OFS_STEP) begin
				HRDATA[15:0] <= step;
			end else if (HADDR[7:0] == OFS_STATUS) begin
				HRDATA[4:0] <= {STALL_ACT, PB_ACT, DECEL, OUT_EN, state == ST_RUN};
			end else if (HADDR[7:0] == OFS_OUT) begin
				HRDATA[15:0] <= OUT_FREQ;
			end else begin
				for (int k = 0; k < 3; k++) begin
					if (HADDR[7:0] == OFS_BAND + 8'(8 * k)) begin
						HRDATA[15:0] <= floor_f[k];
					end else if (HADDR[7:0] == OFS_BAND + 8'(8 * k + 4)) begin
						HRDATA[15:0] <= ceil_f[k];
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Setting registers.
	// ----------------------------------------

	// Writes other than to hidden limits are brought into range rather than refused, so
	// software reads back the value the block uses unless the maximum or the limit settings later change.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			run_cmd <= 1'b0;
			stop_m <= STOP_DEC;
			lim_en <= 1'b0; // see (RL6)
			jump_en <= 1'b0; // see (RL10)
			stall_sel <= 1'b0;
			fref <= 16'h0000;
			start_f <= START_RST; // see (RL4)
			max_f <= MAX_RST; // see (RL5)
			lim_lo <= LIM_LO_RST; // see (RL9)
			lim_hi <= MAX_RST; // see (RL9)
			base_f <= BASE_RST;
			dc_thr <= DC_THR_RST;
			step <= STEP_RST;
			floor_f <= FLOOR_RST; // see (RL13)
			ceil_f <= CEIL_RST;
		end else if (wr_pend) begin
			if (wr_addr == OFS_CTRL) begin
				run_cmd <= wdat[CTRL_RUN];
				stop_m <= wdat[CTRL_STOP_LSB+:3];
				lim_en <= wdat[CTRL_LIM];
				jump_en <= wdat[CTRL_JUMP];
				stall_sel <= wdat[CTRL_STALL];
			end else if (wr_addr == OFS_FREF) begin
				fref <= cap(sat(wdat, 16'h0000, max_f)); // see (RL5)
			end else if (wr_addr == OFS_START) begin
				start_f <= cap(sat(wdat, START_MIN, START_MAX)); // see (RL4)
			end else if (wr_addr == OFS_MAX) begin
				max_f <= sat(wdat, MAX_MIN, MAX_MAX); // see (RL5)
			end else if (wr_addr == OFS_LIM_LO) begin
				// Hidden limits ignore writes while limits are off.
				if (lim_en) begin
					lim_lo <= sat(wdat, 16'h0000, max_f); // see (RL7) see (RL9)
				end
			end else if (wr_addr == OFS_LIM_HI) begin
				if (lim_en) begin
					lim_hi <= sat(wdat, lim_lo, max_f); // see (RL7)
				end
			end else if (wr_addr == OFS_BASE) begin
				base_f <= sat(wdat, 16'h0000, max_f); // see (RL8)
			end else if (wr_addr == OFS_DC_THR) begin
				dc_thr <= wdat;
			end else if (wr_addr == OFS_STEP) begin
				step <= (wdat == 16'h0000) ? STEP_RST : wdat;
			end else begin
				for (int k = 0; k < 3; k++) begin
					if (wr_addr == OFS_BAND + 8'(8 * k)) begin
						floor_f[k] <= cap(sat(wdat, 16'h0000, ceil_f[k])); // see (RL13)
					end else if (wr_addr == OFS_BAND + 8'(8 * k + 4)) begin
						ceil_f[k] <= cap(sat(wdat, floor_f[k], max_f)); // see (RL13)
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Ramp tick.
	// ----------------------------------------
	assign tick = (tick_cnt == '0);

	// Free running divider that paces every ramp step.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= '0;
		end else if (tick) begin
			tick_cnt <= ($clog2(TICK_CYC))'(TICK_CYC - 1);
		end else begin
			tick_cnt <= tick_cnt - 1'b1;
		end
	end

	// ----------------------------------------
	// Braking conditions.
	// ----------------------------------------

	// Both act only while decelerating; braking masks stall prevention.
	assign pb_hold = (state == ST_DECEL) && (stop_m == STOP_PB) && (DC_LINK_V > dc_thr); // see (RL2) see (RL3)
	assign stall_hold = (state == ST_DECEL) && stall_sel && STALL_REQ && !pb_hold; // see (RL3)

	// Status outputs, registered.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			PB_ACT <= 1'b0;
			STALL_ACT <= 1'b0;
			DECEL <= 1'b0;
		end else begin
			PB_ACT <= pb_hold;
			STALL_ACT <= stall_hold;
			DECEL <= (state == ST_DECEL);
		end
	end

	// ----------------------------------------
	// Stop sequencer and output frequency.
	// ----------------------------------------

	// A held deceleration flattens the slope instead of reaccelerating, which
	// keeps the sequence monotone at the cost of a longer stop.
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_STOP;
			OUT_EN <= 1'b0;
			OUT_FREQ <= 16'h0000;
		end else begin
			case (state)
				ST_STOP: begin
					OUT_FREQ <= 16'h0000;
					if (run_cmd) begin
						state <= ST_RUN;
						OUT_EN <= 1'b1;
					end
				end
				ST_RUN: begin
					if (!run_cmd && stop_m == STOP_FREE) begin
						// Output blocked at once, the load coasts.
						state <= ST_STOP; // see (RL1)
						OUT_EN <= 1'b0; // see (RL1)
						OUT_FREQ <= 16'h0000; // see (RL1)
					end else if (!run_cmd) begin
						state <= ST_DECEL; // see (RL14)
					end else if (tick) begin
						OUT_FREQ <= ramp(OUT_FREQ, target); // see (RL10) see (RL12)
					end
				end
				ST_DECEL: begin
					if (run_cmd) begin
						state <= ST_RUN;
					end else if (OUT_FREQ == 16'h0000) begin
						state <= ST_STOP; // see (RL14)
						OUT_EN <= 1'b0;
					end else if (tick && !pb_hold && !stall_hold) begin
						OUT_FREQ <= ramp(OUT_FREQ, 16'h0000); // see (RL2) see (RL14)
					end
				end
				default: begin
					state <= ST_STOP;
					OUT_EN <= 1'b0;
				end
			endcase
		end
	end

endmodule : dsl_limiter

/* rtl/dsl_pkg.sv */
// Constants, types and helpers shared by the stop and frequency limiter.
// Assumes frequencies in 0.01 Hz steps, 16 bits wide, and a 100 MHz clock.
//
// Operation
// (RL1) Coast stop: output off at once.
// (RL2) Power braking holds slope on high DC link.
// (RL3) Braking, stall only decelerating; braking wins.
// (RL4) Below start frequency becomes zero.
// (RL5) Everything clamped to maximum frequency.
// (RL6) Limit enable off by default, enables clamping.
// (RL7) Limit settings hidden while limits off.
// (RL8) Speed settings capped at upper limit.
// (RL9) Lower limit default 0.50, upper equals maximum.
// (RL10) Skip bands off by default, never settle inside.
// (RL11) Rising request in band holds at floor.
// (RL12) Ramps pass straight through skip bands.
// (RL13) Three bands, floor not above ceiling.
// (RL14) Default stop ramps down to zero.
// (RL15) Order: clamp, skip hold, start zeroing.
package dsl_pkg;

	// ----------------------------------------
	// Register byte offsets.
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FREF = 8'h04;
	localparam logic [7:0] OFS_START = 8'h08;
	localparam logic [7:0] OFS_MAX = 8'h0C;
	localparam logic [7:0] OFS_LIM_LO = 8'h10;
	localparam logic [7:0] OFS_LIM_HI = 8'h14;
	localparam logic [7:0] OFS_BASE = 8'h18;
	localparam logic [7:0] OFS_DC_THR = 8'h1C;
	localparam logic [7:0] OFS_BAND = 8'h20; // Floor at +8k, ceiling at +8k+4.
	localparam logic [7:0] OFS_STEP = 8'h38;
	localparam logic [7:0] OFS_STATUS = 8'h3C;
	localparam logic [7:0] OFS_OUT = 8'h40;

	// ----------------------------------------
	// Control bit positions.
	// ----------------------------------------
	localparam int CTRL_RUN = 0;
	localparam int CTRL_STOP_LSB = 1; // Three bits of stop method.
	localparam int CTRL_LIM = 4;
	localparam int CTRL_JUMP = 5;
	localparam int CTRL_STALL = 6;

	// Stop method codes.
	localparam logic [2:0] STOP_DEC = 3'h0;
	localparam logic [2:0] STOP_FREE = 3'h2;
	localparam logic [2:0] STOP_PB = 3'h4;

	// ----------------------------------------
	// Values after reset and setting ranges, in 0.01 Hz apart from the DC link threshold.
	// ----------------------------------------
	localparam logic [15:0] START_RST = 16'h0032;
	localparam logic [15:0] START_MIN = 16'h0001;
	localparam logic [15:0] START_MAX = 16'h03E8;
	localparam logic [15:0] MAX_RST = 16'h1770;
	localparam logic [15:0] MAX_MIN = 16'h0FA0;
	localparam logic [15:0] MAX_MAX = 16'h9C40;
	localparam logic [15:0] LIM_LO_RST = 16'h0032;
	localparam logic [15:0] BASE_RST = 16'h1770;
	localparam logic [15:0] DC_THR_RST = 16'h02EE;
	localparam logic [15:0] STEP_RST = 16'h0001;
	localparam logic [15:0] FLOOR_RST [3] = '{16'h03E8, 16'h07D0, 16'h0BB8};
	localparam logic [15:0] CEIL_RST [3] = '{16'h05DC, 16'h09C4, 16'h0DAC};

	// ----------------------------------------
	// Timing of the ramp tick.
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RAMP_TICK_NS = 1000;
	localparam int TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;

	// Ramp and stop sequencer states.
	typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_DECEL} dsl_state_e;

	// Clamp a value between two bounds; the lower bound wins if they cross.
	function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		logic [15:0] r;
		r = (v > hi) ? hi : v;
		sat = (r < lo) ? lo : r;
	endfunction : sat

endpackage : dsl_pkg

/* rtl/dsl_rst_sync.sv */
// Reset synchroniser for the limiter.
// Assumes an active low asynchronous reset; release follows two clock edges.
`timescale 1ns/1ns
module dsl_rst_sync (
	input wire logic clk,
	input wire logic arst_n,
	output logic rst_n
);
	logic meta; // First stage, read only by the second stage.

	// Assert at once, release through two flops to avoid metastable release.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			meta <= 1'b1;
			rst_n <= meta;
		end
	end
endmodule : dsl_rst_sync

/* verif/dsl_drive_model.sv */
// Model of the power stage and stall source facing the limiter.
// Assumes the bench commands regeneration and stall requests.
`timescale 1ns/1ns
module dsl_drive_model #(
	parameter logic [15:0] DC_HI = 16'h0300, // Above the reset threshold.
	parameter logic [15:0] DC_LO = 16'h0200 // Below the reset threshold.
) (
	input wire logic clk,
	input wire logic regen,
	input wire logic stall_cmd,
	output logic [15:0] dc_link_v,
	output logic stall_req
);
	// The link voltage follows the regeneration command one edge late,
	// as a real link lags the energy fed back into it.
	always_ff @(posedge clk) begin
		dc_link_v <= regen ? DC_HI : DC_LO;
		stall_req <= stall_cmd;
	end
	// No separate start value: a second process on these variables would give
	// them two drivers. The bench holds the design in reset well past the first
	// edge, so the unknown span before it is never seen.
endmodule : dsl_drive_model

/* verif/dsl_limiter_monitor.sv */
// Concurrent checks on the outputs of the stop and frequency limiter.
// Assumes it is bound to dsl_limiter and sees only that module's ports.
`timescale 1ns/1ns
module dsl_limiter_chk
	import dsl_pkg::*;
#(
	parameter int FW = 16 // Frequency word width, as in the design.
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic OUT_EN,
	input wire logic [15:0] OUT_FREQ,
	input wire logic DECEL,
	input wire logic PB_ACT,
	input wire logic STALL_ACT
);
	// ----------------------------------------
	// Helper: cycles since the last ramp step.
	// ----------------------------------------
	logic [15:0] prev_f; // Output frequency one cycle ago.
	logic [7:0] gap; // Saturating count of cycles since the last step.

	// Coast drops are left out because they need not land on a tick.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			prev_f <= 16'h0000;
			gap <= 8'hFF;
		end else begin
			prev_f <= OUT_FREQ;
			if (OUT_EN && OUT_FREQ != prev_f) begin
				gap <= 8'h00;
			end else if (gap != 8'hFF) begin
				gap <= gap + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Properties.
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_pb_held;
		PB_ACT [*3];
	endsequence
	sequence s_step;
		OUT_EN && $changed(OUT_FREQ);
	endsequence

	property p_bus_okay;
		HREADYOUT && !HRESP;
	endproperty
	property p_rdata_hi;
		HRDATA[31:16] == 16'h0000;
	endproperty
	property p_freq_max;
		OUT_FREQ <= MAX_MAX;
	endproperty
	property p_freq_en;
		OUT_FREQ != 16'h0000 |-> OUT_EN;
	endproperty
	property p_pb_decel;
		PB_ACT |-> DECEL;
	endproperty
	property p_stall_decel;
		STALL_ACT |-> DECEL;
	endproperty
	property p_pb_wins;
		PB_ACT |-> !STALL_ACT;
	endproperty
	property p_pb_hold;
		s_pb_held |-> $stable(OUT_FREQ);
	endproperty
	property p_ramp_zero;
		$fell(OUT_EN) && $past(DECEL) |-> $past(OUT_FREQ) == 16'h0000;
	endproperty
	// Steps come only on the 100 cycle tick, so a band is crossed in one.
	property p_step_gap;
		s_step |-> gap >= 8'h63;
	endproperty

	a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready and okay");
	a_rdata_hi: assert property (p_rdata_hi) else $error("unused read bits set");
	a_freq_max: assert property (p_freq_max) else $error("output above maximum range");
	a_freq_en: assert property (p_freq_en) else $error("frequency while output off");
	a_pb_decel: assert property (p_pb_decel) else $error("braking outside decel");
	a_stall_decel: assert property (p_stall_decel) else $error("stall hold outside decel");
	a_pb_wins: assert property (p_pb_wins) else $error("stall active with braking");
	a_pb_hold: assert property (p_pb_hold) else $error("frequency moved while braking");
	a_ramp_zero: assert property (p_ramp_zero) else $error("ramp stop ended above zero");
	a_step_gap: assert property (p_step_gap) else $error("steps closer than one tick");
endmodule : dsl_limiter_chk

bind dsl_limiter dsl_limiter_chk #(.FW(FW)) u_dsl_limiter_chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .OUT_EN(OUT_EN), .OUT_FREQ(OUT_FREQ),
	.DECEL(DECEL), .PB_ACT(PB_ACT), .STALL_ACT(STALL_ACT));

/* verif/dsl_limiter_tb_top.sv */
// Self-checking bench for the stop and frequency limiter.
// Assumes a single AHB-Lite master and the drive model on the far side.
`timescale 1ns/1ns
module dsl_limiter_tb_top
	import dsl_pkg::*;
;
	logic clk, rst_n, hsel, hwrite, hready, hresp, regen, stall_cmd, stall_req;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [15:0] dc_v, out_f;
	logic out_en, decel, pb, stall_act;
	int bad_count, n_checks;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// The slave's ready output is the bus ready.
	dsl_limiter #(.FW(16)) u_dsl_limiter (.REF_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(hresp), .DC_LINK_V(dc_v), .STALL_REQ(stall_req), .OUT_EN(out_en),
		.OUT_FREQ(out_f), .DECEL(decel), .PB_ACT(pb), .STALL_ACT(stall_act));
	dsl_drive_model u_dsl_drive_model (.clk(clk), .regen(regen), .stall_cmd(stall_cmd),
		.dc_link_v(dc_v), .stall_req(stall_req));

	// ----------------------------------------
	// Shared tasks.
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single transfer; waits on ready rather than assuming a latency.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, d};
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 16'h0000, q);
		chk(q[15:0], exp);
	endtask : rdc

	task automatic tick(input int n);
		repeat (n * TICK_CYC) @(posedge clk);
	endtask : tick

	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_defaults;
		rdc(OFS_CTRL, 16'h0000);
		rdc(OFS_START, 16'h0032);
		rdc(OFS_MAX, 16'h1770);
		rdc(OFS_LIM_LO, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			rdc(8'(OFS_BAND + 8 * k), FLOOR_RST[k]);
			rdc(8'(OFS_BAND + 8 * k + 4), CEIL_RST[k]);
		end
		rdc(8'h80, 16'h0000);
	endtask : t_defaults

	// Hidden limits ignore writes; enabled limits cap speeds but not base.
	task automatic t_limits;
		wr(OFS_LIM_LO, 16'h0100);
		wr(OFS_CTRL, 16'h0010);
		rdc(OFS_LIM_LO, 16'h0032);
		rdc(OFS_LIM_HI, 16'h1770);
		wr(OFS_LIM_HI, 16'h0FA0);
		wr(OFS_FREF, 16'h1770);
		rdc(OFS_FREF, 16'h0FA0);
		wr(OFS_BASE, 16'h1700);
		rdc(OFS_BASE, 16'h1700);
		wr(OFS_STEP, 16'hFFFF);
		wr(OFS_CTRL, 16'h0011);
		tick(3);
		chk(out_f, 16'h0FA0);
		wr(OFS_FREF, 16'h0001);
		tick(3);
		chk(out_f, 16'h0032);
		wr(OFS_CTRL, 16'h0000);
		tick(3);
		chk(out_en, 1'b0);
	endtask : t_limits

	task automatic t_max;
		wr(OFS_FREF, 16'hFFFF);
		wr(OFS_CTRL, 16'h0001);
		tick(3);
		chk(out_f, 16'h1770);
		wr(OFS_CTRL, 16'h0000);
		tick(3);
		chk(out_f, 16'h0000);
	endtask : t_max

	task automatic t_jump;
		wr(OFS_CTRL, 16'h0021);
		wr(OFS_FREF, 16'h04B0);
		tick(3);
		chk(out_f, 16'h03E8);
		wr(OFS_FREF, 16'h05DD);
		tick(3);
		chk(out_f, 16'h05DD);
		wr(OFS_FREF, 16'h0031);
		tick(3);
		chk(out_f, 16'h0000);
		wr(OFS_FREF, 16'h0032);
		tick(3);
		chk(out_f, 16'h0032);
		wr(OFS_CTRL, 16'h0000);
		tick(3);
	endtask : t_jump

	// Coast must drop the output on the edge after run is removed.
	task automatic t_coast;
		wr(OFS_FREF, 16'h1000);
		wr(OFS_CTRL, 16'h0005);
		tick(2);
		chk(out_en, 1'b1);
		wr(OFS_CTRL, 16'h0004);
		@(posedge clk);
		#1;
		chk(out_en, 1'b0);
		chk(out_f, 16'h0000);
	endtask : t_coast

	// Skip bands on: a step of 0x400 lands inside a band both ways and must be carried through it.
	task automatic t_decel;
		wr(OFS_STEP, 16'h0400);
		wr(OFS_CTRL, 16'h0021);
		repeat (2 * TICK_CYC) begin
			@(posedge clk);
			if (out_f != 16'h0000) begin
				break;
			end
		end
		chk(out_f, CEIL_RST[0]);
		tick(6);
		chk(out_f, 16'h1000);
		wr(OFS_CTRL, 16'h0020);
		tick(1);
		chk(decel, 1'b1);
		chk(out_en, 1'b1);
		repeat (2 * TICK_CYC) begin
			@(posedge clk);
			if (out_f != 16'h1000) begin
				break;
			end
		end
		chk(out_f, FLOOR_RST[2]);
		tick(5);
		chk(out_en, 1'b0);
	endtask : t_decel

	// Braking and stall both requested; braking must hold and win.
	task automatic t_brake;
		wr(OFS_CTRL, 16'h0049);
		tick(6);
		@(posedge clk);
		regen <= 1'b1;
		stall_cmd <= 1'b1;
		tick(1);
		chk(pb, 1'b0);
		chk(stall_act, 1'b0);
		wr(OFS_CTRL, 16'h0048);
		tick(3);
		chk(pb, 1'b1);
		chk(stall_act, 1'b0);
		chk(out_f, 16'h1000);
		rdc(OFS_STATUS, 16'h000E);
		rdc(OFS_OUT, 16'h1000);
		@(posedge clk);
		regen <= 1'b0;
		tick(2);
		chk(stall_act, 1'b1);
		@(posedge clk);
		stall_cmd <= 1'b0;
		tick(6);
		chk(out_en, 1'b0);
	endtask : t_brake

	task automatic summarize;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	// Whole run is well under 20000 cycles; this cuts a hang short.
	initial begin
		#500000;
		bad_count++;
		summarize();
	end

	initial begin
		{hsel, hwrite, regen, stall_cmd, rst_n} = 5'h00;
		htrans = 2'h0;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		bad_count = 0;
		n_checks = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_defaults();
		t_limits();
		t_max();
		t_jump();
		t_coast();
		t_decel();
		t_brake();
		summarize();
	end
endmodule : dsl_limiter_tb_top
